//--- core/pcc_pkg.sv
/*
  Constants for the oscillator and PLL clock control block: register offsets,
  field positions, reset values, timing counts and the crystal table.
  Assumes a 10 MHz APB clock and 32-bit word-aligned registers.
*/
package pcc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_RUN_CFG    = 8'h00;
  localparam logic [7:0] OFS_RUN_CFG2   = 8'h04;
  localparam logic [7:0] OFS_OSC_CAL    = 8'h08;
  localparam logic [7:0] OFS_OSC_STAT   = 8'h0C;
  localparam logic [7:0] OFS_PLL_TRANS  = 8'h10;
  localparam logic [7:0] OFS_RAW_INT    = 8'h14;
  localparam logic [7:0] OFS_INT_MASK   = 8'h18;
  localparam logic [7:0] OFS_RST_CAUSE  = 8'h1C;
  localparam logic [7:0] OFS_MAIN_OSC_CTL   = 8'h20;
  localparam logic [7:0] OFS_RELOCK_CNT = 8'h24;

  // Run clock config fields
  localparam int RC_IOSC_DIS  = 0;
  localparam int RC_CRYSTAL_SELECT_LSB  = 6;
  localparam int RC_BYPASS    = 11;
  localparam int RC_PWRDN     = 13;
  localparam int RC_DIV_LSB   = 23;
  // Second run clock config fields
  localparam int RC2_SRC_LSB  = 4;
  localparam int RC2_HALF     = 22;
  localparam int RC2_DIV_LSB  = 23;
  localparam int RC2_UNDIV    = 30;
  localparam int RC2_USE      = 31;
  // Calibration register fields
  localparam int CAL_UT_LSB   = 0;
  localparam int CAL_USER_TRIM_ENABLE     = 8;
  localparam int CAL_AUTO     = 9;
  localparam int CAL_UPDATE   = 31;
  // Statistic register fields
  localparam int STAT_RES_LSB = 8;
  // Status and control bits
  localparam int RIS_PLL_LOCK = 6;
  localparam int RESET_CAUSE_REGISTER_MAIN_OSC    = 16;
  localparam int MAIN_OSC_CHECK   = 0;

  // Reset values and the internal source select code
  localparam logic [4:0]  CRYSTAL_SELECT_RESET    = 5'h0F;
  localparam logic [3:0]  SYSCLK_DIVIDER_RESET  = 4'hF;
  localparam logic [5:0]  SYSCLK_DIVIDER_EXT_RESET = 6'h0F;
  localparam logic [2:0]  SRC_INTERNAL  = 3'h1;
  localparam logic [6:0]  FACTORY_TRIM  = 7'h40;

  // Relock counts and threshold
  localparam logic [15:0] RELOCK_SHORT  = 16'h1200;
  localparam logic [15:0] RELOCK_LONG   = 16'h2400;
  localparam logic [15:0] SLOW_CRYSTAL_SELECT_KHZ = 16'h2000;

  // PLL target and internal oscillator
  localparam logic [19:0] VCO_KHZ       = 20'h6_1A80;
  localparam logic [15:0] IOSC_KHZ      = 16'h3E80;

  // Internal power-on reset after a main oscillator failure
  localparam int POR_IOSC_PERIODS = 32;
  localparam int IOSC_PERIOD_PS   = 62500;
  localparam int PCLK_PERIOD_PS   = 100000;
  localparam int POR_CYCLES =
    (POR_IOSC_PERIODS * IOSC_PERIOD_PS + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS;

  // Crystal number to frequency in kHz
  function automatic logic [15:0] crystal_select_khz(input logic [4:0] x);
    case (x)
      5'h04:   crystal_select_khz = 16'h0DFB;
      5'h05:   crystal_select_khz = 16'h0E66;
      5'h06:   crystal_select_khz = 16'h0FA0;
      5'h07:   crystal_select_khz = 16'h1000;
      5'h08:   crystal_select_khz = 16'h1333;
      5'h09:   crystal_select_khz = 16'h1388;
      5'h0A:   crystal_select_khz = 16'h1400;
      5'h0B:   crystal_select_khz = 16'h1770;
      5'h0C:   crystal_select_khz = 16'h1800;
      5'h0D:   crystal_select_khz = 16'h1CCC;
      5'h0E:   crystal_select_khz = 16'h1F40;
      5'h0F:   crystal_select_khz = 16'h2000;
      5'h10:   crystal_select_khz = 16'h2710;
      5'h11:   crystal_select_khz = 16'h2EE0;
      5'h12:   crystal_select_khz = 16'h3000;
      5'h13:   crystal_select_khz = 16'h34F8;
      5'h14:   crystal_select_khz = 16'h37EE;
      5'h15:   crystal_select_khz = 16'h3E80;
      default: crystal_select_khz = 16'h4000;
    endcase
  endfunction

endpackage

//--- core/pcc_relock_counter.sv
/*
  Down counter timing the PLL relock period on the system clock.
  Assumes start is a one-cycle pulse from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pcc_relock_counter #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         start,
  input  wire logic [W-1:0] load_val,
  output var  logic [W-1:0] count_q,
  output var  logic         busy_q,
  output var  logic         expired_q
);

  initial begin
    if (W < 2) $error("relock counter too narrow");
  end

  wire last = busy_q && (count_q == W'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q   <= '0;
      busy_q    <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      expired_q <= last && !start;
      if (start) begin
        count_q <= load_val;
        busy_q  <= 1'b1;
      end else if (busy_q) begin
        count_q <= count_q - W'(1);
        busy_q  <= !last;
      end
    end
  end

endmodule
`default_nettype wire

//--- core/pcc_clock_control.sv
/*
  Oscillator trim, PLL configuration, relock hold-off and main oscillator
  failure fallback, with an APB register slave.
  Assumes pclk at 10 MHz, presetn from power-on reset, and that the
  oscillator fault input arrives asynchronously.
*/
// Summary of operation
// - Internal oscillator runs from reset; its disable acts only in Deep-Sleep.
// - Update with user trim off restores the factory trim.
// - Update with user trim on applies user trim glitch-free; larger means longer period.
// - Auto-calibrate starts against 32.768 kHz; result and trim reported, trim applied.
// - A different crystal value retranslates and updates PLL settings.
// - Translation register shows crystal-to-PLL setting within 2 percent of VCO.
// - PLL is powered down after reset until software enables it.
// - 400 MHz VCO is halved before the divisor unless second config use and undivided select are both set.
// - Oscillator source 0x1 selects internal oscillator as PLL reference.
// - Normal mode drives PLL output; power-down leaves it undriven.
// - Relock starts on crystal change or power-down to normal; same value no.
// - System-clock down counter loads 0x1200 for slow main osc, else 0x2400.
// - Enable and select PLL in one write: switch only after relock expires.
// - Raw lock status bit reported, with an enableable lock interrupt.
// - Oscillator check enable monitors main oscillator and flags out-of-band.
// - On failure set fail cause, enable internal oscillator, switch clock to it.
// - Then internal reset for 32 internal periods; NMI request in the same cycle as the release.
// - System clock divisor is divider field plus one.
// - With second config use and undivided select set, bit 22 becomes extended divider LSB.
`timescale 1ns/1ps
`default_nettype none
module pcc_clock_control
  import pcc_pkg::*;
#(
  parameter int          CW          = 16,
  parameter logic [15:0] RELOCK_SLOW = RELOCK_SHORT,
  parameter logic [15:0] RELOCK_FAST = RELOCK_LONG
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        deep_sleep,
  input  wire logic        main_osc_fault,
  input  wire logic        cal_done,
  input  wire logic [1:0]  cal_result,
  input  wire logic [6:0]  returned_trim_value,
  output var  logic        cal_start,
  output var  logic        internal_osc_enable,
  output var  logic [6:0]  osc_trim,
  output var  logic        osc_trim_load,
  output var  logic        pll_power_down,
  output var  logic        pll_out_enable,
  output var  logic        pll_ref_internal,
  output var  logic [9:0]  pll_mult,
  output var  logic        vco_predivide,
  output var  logic [7:0]  sysclk_divisor,
  output var  logic        sysclk_use_pll,
  output var  logic        sysclk_src_internal,
  output var  logic        main_osc_check_active,
  output var  logic        pll_lock_irq,
  output var  logic        internal_reset,
  output var  logic        nmi_request
);

  initial begin
    if (CW < 14) $error("relock counter width too small");
  end

  typedef enum logic [2:0] {
    PCC_RUN  = 3'b001,
    PCC_POR  = 3'b010,
    PCC_NMI  = 3'b100
  } pcc_fail_e;

  // Registered state
  logic       iosc_dis_q, bypass_q, pwrdn_q, use2_q, undiv_q, half_q;
  logic [4:0] crystal_select_q;
  logic [3:0] sysclk_divider_q;
  logic [5:0] sysclk_divider_ext_q;
  logic [2:0] osc_src_q;
  logic       user_trim_enable_q, lock_mask_q, osc_check_enable_q;
  logic [6:0] user_trim_value_q;
  logic [1:0] cal_result_q;
  logic [6:0] cal_trim_q;
  logic       cal_busy_q, pll_lock_raw_flag_q, main_osc_fail_flag_q;
  logic       fallback_q, pwrdn_prev_q;
  logic       fault_s1_q, fault_s2_q;
  logic [4:0] por_cnt_q;
  pcc_fail_e  fail_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;

  // APB decode
  wire setup   = psel && !penable;
  wire wr      = psel && penable && pwrite;
  wire wr_rc   = wr && (paddr == OFS_RUN_CFG);
  wire wr_rc2  = wr && (paddr == OFS_RUN_CFG2);
  wire wr_cal  = wr && (paddr == OFS_OSC_CAL);
  wire wr_msk  = wr && (paddr == OFS_INT_MASK);
  wire wr_reset_cause_register = wr && (paddr == OFS_RST_CAUSE);
  wire wr_mctl = wr && (paddr == OFS_MAIN_OSC_CTL);
  wire [4:0] new_crystal_select = pwdata[RC_CRYSTAL_SELECT_LSB +: 5];

  // Relock start on crystal change or power-up of the PLL
  wire crystal_select_change  = wr_rc && (new_crystal_select != crystal_select_q);
  wire pll_powerup  = pwrdn_prev_q && !pwrdn_q;
  wire relock_start = crystal_select_change || pll_powerup;
  wire        sysclk_src_d_w = (osc_src_q == SRC_INTERNAL) || fallback_q;
  wire [4:0]  next_crystal_select  = crystal_select_change ? new_crystal_select : crystal_select_q;
  wire [15:0] cur_khz    = crystal_select_khz(crystal_select_q);
  wire [15:0] next_khz   = crystal_select_khz(next_crystal_select);
  wire [15:0] ref_khz    = (osc_src_q == SRC_INTERNAL) ? IOSC_KHZ : cur_khz;
  wire        main_slow  = !sysclk_src_d_w && (next_khz <= SLOW_CRYSTAL_SELECT_KHZ);
  wire [15:0] relock_val = main_slow ? RELOCK_SLOW : RELOCK_FAST;

  logic [CW-1:0] relock_cnt;
  logic          relock_busy, relock_expired;

  pcc_relock_counter #(
    .W (CW)
  ) u_relock (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (relock_start),
    .load_val  (CW'(relock_val)),
    .count_q   (relock_cnt),
    .busy_q    (relock_busy),
    .expired_q (relock_expired)
  );

  // Crystal translation: multiplier rounded to the nearest integer
  wire [19:0] ref_k     = {4'h0, ref_khz};
  wire [19:0] mult_full = (VCO_KHZ + (ref_k >> 1)) / ref_k;
  wire [9:0]  mult_w    = mult_full[9:0];
  wire [9:0]  crystal_select_mult_w = 10'((VCO_KHZ + {5'h0, cur_khz[15:1]}) /
                                {4'h0, cur_khz});

  // Divisor selection
  wire [6:0] div_code = !use2_q  ? {3'h0, sysclk_divider_q} :
                        undiv_q  ? {sysclk_divider_ext_q, half_q} :
                                   {1'b0, sysclk_divider_ext_q};
  wire [7:0] divisor_w = {1'b0, div_code} + 8'h01;

  // Fault detection
  wire fault_hit = osc_check_enable_q && fault_s2_q && (fail_q == PCC_RUN);

  // Read mux
  logic [31:0] rdata_w;
  logic        unmapped_w;
  always_comb begin
    rdata_w    = 32'h0000_0000;
    unmapped_w = 1'b0;
    case (paddr)
      OFS_RUN_CFG: begin
        rdata_w[RC_IOSC_DIS]           = iosc_dis_q;
        rdata_w[RC_CRYSTAL_SELECT_LSB +: 5]      = crystal_select_q;
        rdata_w[RC_BYPASS]             = bypass_q;
        rdata_w[RC_PWRDN]              = pwrdn_q;
        rdata_w[RC_DIV_LSB +: 4]       = sysclk_divider_q;
      end
      OFS_RUN_CFG2: begin
        rdata_w[RC2_SRC_LSB +: 3]      = osc_src_q;
        rdata_w[RC2_HALF]              = half_q;
        rdata_w[RC2_DIV_LSB +: 6]      = sysclk_divider_ext_q;
        rdata_w[RC2_UNDIV]             = undiv_q;
        rdata_w[RC2_USE]               = use2_q;
      end
      OFS_OSC_CAL: begin
        rdata_w[CAL_UT_LSB +: 7]       = user_trim_value_q;
        rdata_w[CAL_USER_TRIM_ENABLE]              = user_trim_enable_q;
        rdata_w[CAL_AUTO]              = cal_busy_q;
      end
      OFS_OSC_STAT: begin
        rdata_w[6:0]                   = cal_trim_q;
        rdata_w[STAT_RES_LSB +: 2]     = cal_result_q;
      end
      OFS_PLL_TRANS:  rdata_w[9:0]     = crystal_select_mult_w;
      OFS_RAW_INT:    rdata_w[RIS_PLL_LOCK] = pll_lock_raw_flag_q;
      OFS_INT_MASK:   rdata_w[RIS_PLL_LOCK] = lock_mask_q;
      OFS_RST_CAUSE:  rdata_w[RESET_CAUSE_REGISTER_MAIN_OSC]    = main_osc_fail_flag_q;
      OFS_MAIN_OSC_CTL:   rdata_w[MAIN_OSC_CHECK]   = osc_check_enable_q;
      OFS_RELOCK_CNT: rdata_w[CW-1:0]       = relock_cnt;
      default:        unmapped_w = 1'b1;
    endcase
  end

  // APB answer: data captured in setup, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= 1'b1;
      if (setup) begin
        prdata_q  <= rdata_w;
        pslverr_q <= unmapped_w;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iosc_dis_q           <= 1'b0;
      crystal_select_q     <= CRYSTAL_SELECT_RESET;
      bypass_q             <= 1'b1;
      pwrdn_q              <= 1'b1;
      sysclk_divider_q     <= SYSCLK_DIVIDER_RESET;
      use2_q               <= 1'b0;
      osc_src_q            <= 3'h0;
      half_q               <= 1'b0;
      undiv_q              <= 1'b0;
      sysclk_divider_ext_q <= SYSCLK_DIVIDER_EXT_RESET;
      lock_mask_q          <= 1'b0;
      osc_check_enable_q   <= 1'b0;
      pwrdn_prev_q         <= 1'b1;
    end else begin
      pwrdn_prev_q <= pwrdn_q;
      if (wr_rc) begin
        iosc_dis_q       <= pwdata[RC_IOSC_DIS];
        crystal_select_q <= new_crystal_select;
        bypass_q         <= pwdata[RC_BYPASS];
        pwrdn_q          <= pwdata[RC_PWRDN];
        sysclk_divider_q <= pwdata[RC_DIV_LSB +: 4];
      end
      if (wr_rc2) begin
        osc_src_q            <= pwdata[RC2_SRC_LSB +: 3];
        half_q               <= pwdata[RC2_HALF];
        sysclk_divider_ext_q <= pwdata[RC2_DIV_LSB +: 6];
        undiv_q              <= pwdata[RC2_UNDIV];
        use2_q               <= pwdata[RC2_USE];
      end
      if (wr_msk) lock_mask_q <= pwdata[RIS_PLL_LOCK];
      if (wr_mctl) osc_check_enable_q <= pwdata[MAIN_OSC_CHECK];
    end
  end

  // Trim and calibration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_trim_enable_q  <= 1'b0;
      user_trim_value_q   <= FACTORY_TRIM;
      osc_trim            <= FACTORY_TRIM;
      osc_trim_load       <= 1'b0;
      cal_start           <= 1'b0;
      cal_busy_q          <= 1'b0;
      cal_result_q        <= 2'h0;
      cal_trim_q          <= FACTORY_TRIM;
    end else begin
      osc_trim_load <= 1'b0;
      cal_start     <= 1'b0;
      if (cal_done && cal_busy_q) begin
        cal_busy_q    <= 1'b0;
        cal_result_q  <= cal_result;
        cal_trim_q    <= returned_trim_value;
        osc_trim      <= returned_trim_value;
        osc_trim_load <= 1'b1;
      end
      if (wr_cal) begin
        user_trim_enable_q <= pwdata[CAL_USER_TRIM_ENABLE];
        user_trim_value_q  <= pwdata[CAL_UT_LSB +: 7];
        if (pwdata[CAL_UPDATE]) begin
          osc_trim      <= pwdata[CAL_USER_TRIM_ENABLE] ? pwdata[CAL_UT_LSB +: 7] : FACTORY_TRIM;
          osc_trim_load <= 1'b1;
        end
        if (pwdata[CAL_AUTO] && !cal_busy_q) begin
          cal_start  <= 1'b1;
          cal_busy_q <= 1'b1;
        end
      end
    end
  end

  // Lock flag, failure sequence and fault synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_lock_raw_flag_q  <= 1'b0;
      main_osc_fail_flag_q <= 1'b0;
      fallback_q           <= 1'b0;
      fault_s1_q           <= 1'b0;
      fault_s2_q           <= 1'b0;
      fail_q               <= PCC_RUN;
      por_cnt_q            <= 5'h00;
      internal_reset       <= 1'b0;
      nmi_request          <= 1'b0;
    end else begin
      fault_s1_q <= main_osc_fault;
      fault_s2_q <= fault_s1_q;
      if (relock_start) pll_lock_raw_flag_q <= 1'b0;
      else if (relock_expired) pll_lock_raw_flag_q <= 1'b1;
      if (fault_hit) main_osc_fail_flag_q <= 1'b1;
      else if (wr_reset_cause_register && pwdata[RESET_CAUSE_REGISTER_MAIN_OSC]) main_osc_fail_flag_q <= 1'b0;
      nmi_request <= 1'b0;
      case (fail_q)
        PCC_RUN: begin
          if (fault_hit) begin
            fallback_q     <= 1'b1;
            fail_q         <= PCC_POR;
            por_cnt_q      <= 5'(POR_CYCLES - 1);
            internal_reset <= 1'b1;
          end else if (wr_reset_cause_register && pwdata[RESET_CAUSE_REGISTER_MAIN_OSC]) begin
            fallback_q <= 1'b0;
          end
        end
        PCC_POR: begin
          if (por_cnt_q == 5'h00) begin
            internal_reset <= 1'b0;
            nmi_request    <= 1'b1;
            fail_q         <= PCC_NMI;
          end else begin
            por_cnt_q <= por_cnt_q - 5'h01;
          end
        end
        PCC_NMI: fail_q <= PCC_RUN;
        default: fail_q <= PCC_RUN;
      endcase
    end
  end

  // Clock outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_osc_enable   <= 1'b1;
      pll_power_down        <= 1'b1;
      pll_out_enable        <= 1'b0;
      pll_ref_internal      <= 1'b0;
      pll_mult              <= 10'h000;
      vco_predivide         <= 1'b1;
      sysclk_divisor        <= 8'h10;
      sysclk_use_pll        <= 1'b0;
      sysclk_src_internal   <= 1'b1;
      main_osc_check_active <= 1'b0;
      pll_lock_irq          <= 1'b0;
    end else begin
      internal_osc_enable   <= !(iosc_dis_q && deep_sleep) || fallback_q;
      pll_power_down        <= pwrdn_q;
      pll_out_enable        <= !pwrdn_q;
      pll_ref_internal      <= (osc_src_q == SRC_INTERNAL);
      pll_mult              <= mult_w;
      vco_predivide         <= !(use2_q && undiv_q);
      sysclk_divisor        <= divisor_w;
      sysclk_use_pll        <= !bypass_q && !pwrdn_q && !relock_busy && !relock_start &&
                               pll_lock_raw_flag_q && !fallback_q;
      sysclk_src_internal   <= sysclk_src_d_w;
      main_osc_check_active <= osc_check_enable_q;
      pll_lock_irq          <= pll_lock_raw_flag_q && lock_mask_q;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule
`default_nettype wire

//--- testbench/pcc_clock_control_properties.sv
/*
  Port-level checks for the clock control block.
  Assumes one pclk domain and an active-low asynchronous presetn.
*/
`timescale 1ns/1ps
`default_nettype none
module pcc_clock_control_properties
  import pcc_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       cal_done,
  input wire logic [6:0] returned_trim_value,
  input wire logic [6:0] osc_trim,
  input wire logic       osc_trim_load,
  input wire logic       internal_osc_enable,
  input wire logic       pll_power_down,
  input wire logic       pll_out_enable,
  input wire logic       sysclk_use_pll,
  input wire logic       sysclk_src_internal,
  input wire logic       main_osc_check_active,
  input wire logic       internal_reset,
  input wire logic       nmi_request
);
  logic [7:0] ir_cnt_q;
  logic [6:0] trim_q;

  // Length of the internal reset and the last returned trim
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_cnt_q <= 8'h00;
      trim_q   <= 7'h00;
    end else begin
      ir_cnt_q <= internal_reset ? ir_cnt_q + 8'h01 : 8'h00;
      if (cal_done) trim_q <= returned_trim_value;
    end
  end

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  out_enable_a: assert property (pll_out_enable != pll_power_down)
    else $error("pll output enable disagrees with power down");
  cal_trim_a: assert property (cal_done |-> ##[1:2] (osc_trim_load && osc_trim == trim_q))
    else $error("returned trim not applied");
  relock_hold_a: assert property ($fell(pll_power_down) |-> !sysclk_use_pll [*8])
    else $error("pll used during relock");
  check_gate_a: assert property ($rose(internal_reset) |-> $past(main_osc_check_active, 2))
    else $error("fault handled with check disabled");
  fallback_a: assert property ($rose(internal_reset) |->
      ##[0:1] (internal_osc_enable && sysclk_src_internal) ##1 !sysclk_use_pll)
    else $error("no fallback to internal oscillator");
  por_len_a: assert property ($fell(internal_reset) |-> ir_cnt_q == 8'(POR_CYCLES))
    else $error("internal reset length wrong");
  nmi_after_a: assert property ($fell(internal_reset) |-> ##[0:1] nmi_request)
    else $error("no nmi request after internal reset");
  nmi_pulse_a: assert property (nmi_request |=> !nmi_request)
    else $error("nmi request longer than one cycle");

  cover property ($rose(internal_reset));
  cover property ($rose(sysclk_use_pll));
  cover property (osc_trim_load);
endmodule

bind pcc_clock_control pcc_clock_control_properties u_props (.pclk, .presetn, .cal_done,
  .returned_trim_value, .osc_trim, .osc_trim_load, .internal_osc_enable, .pll_power_down,
  .pll_out_enable, .sysclk_use_pll, .sysclk_src_internal, .main_osc_check_active,
  .internal_reset, .nmi_request);
`default_nettype wire

//--- testbench/tb.sv
/*
  Self-checking bench for the clock control block over APB.
  Assumes zero-wait APB and short relock counts set by parameter.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import pcc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        deep_sleep, main_osc_fault, cal_done, cal_start, internal_osc_enable;
  logic [1:0]  cal_result;
  logic [6:0]  returned_trim_value, osc_trim;
  logic        osc_trim_load, pll_power_down, pll_out_enable, pll_ref_internal, vco_predivide;
  logic [9:0]  pll_mult;
  logic [7:0]  sysclk_divisor;
  logic        sysclk_use_pll, sysclk_src_internal, main_osc_check_active;
  logic        pll_lock_irq, internal_reset, nmi_request;
  int          fails, checks_done, cyc, starts, nmis, n;

  pcc_clock_control #(.RELOCK_SLOW(16'h0010), .RELOCK_FAST(16'h0020)) pcc_clock_control_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .deep_sleep, .main_osc_fault, .cal_done, .cal_result, .returned_trim_value, .cal_start,
    .internal_osc_enable, .osc_trim, .osc_trim_load, .pll_power_down, .pll_out_enable,
    .pll_ref_internal, .pll_mult, .vco_predivide, .sysclk_divisor, .sysclk_use_pll,
    .sysclk_src_internal, .main_osc_check_active, .pll_lock_irq, .internal_reset, .nmi_request);

  always #50 pclk = ~pclk;

  // Cycle ceiling and pulse counters
  always @(posedge pclk) begin
    cyc++;
    if (cal_start === 1'b1) starts++;
    if (nmi_request === 1'b1) nmis++;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // One APB transfer: setup, then access until pready
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] xl(input int khz);
    return (400000 + khz / 2) / khz;
  endfunction

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    deep_sleep = 0; main_osc_fault = 0; cal_done = 0; cal_result = 0; returned_trim_value = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    chk("osc_en", internal_osc_enable, 1);
    chk("pwrdn", pll_power_down, 1);
    chk("trim", osc_trim, 32'h0000_0040);
    chk("div", sysclk_divisor, 32'h0000_0010);
    chk("prediv", vco_predivide, 1);
    rw(0, OFS_RUN_CFG, 0); chk("run_cfg", rd, 32'h0780_2BC0);
    rw(0, 8'h30, 0); chk("unmapped", {err_q, rd[30:0]}, 32'h8000_0000);
    $display("reset test done");
    rw(1, OFS_OSC_CAL, 32'h0000_0100);
    rw(1, OFS_OSC_CAL, 32'h0000_0115); tick(3); chk("trim hold", osc_trim, 32'h0000_0040);
    rw(1, OFS_OSC_CAL, 32'h8000_0115); tick(3); chk("user trim", osc_trim, 32'h0000_0015);
    rw(1, OFS_OSC_CAL, 32'h8000_0000); tick(3); chk("factory", osc_trim, 32'h0000_0040);
    rw(1, OFS_OSC_CAL, 32'h0000_0200); tick(3); chk("cal start", starts, 1);
    cal_done <= 1'b1; cal_result <= 2'h2; returned_trim_value <= 7'h2A;
    tick(1); cal_done <= 1'b0; tick(3); chk("cal trim", osc_trim, 32'h0000_002A);
    rw(0, OFS_OSC_STAT, 0); chk("cal stat", rd, 32'h0000_022A);
    $display("trim test done");
    rw(1, OFS_RUN_CFG, 32'h0280_2BC0); tick(3); chk("div5", sysclk_divisor, 6);
    rw(1, OFS_RUN_CFG2, 32'hC240_0000); tick(3); chk("div ext", sysclk_divisor, 10);
    chk("undiv", vco_predivide, 0);
    rw(1, OFS_RUN_CFG2, 32'h0000_0010); tick(3); chk("ref int", pll_ref_internal, 1);
    chk("mult int", pll_mult, xl(IOSC_KHZ));
    chk("prediv2", vco_predivide, 1);
    rw(1, OFS_RUN_CFG2, 0);
    $display("divider test done");
    rw(1, OFS_RUN_CFG, 32'h0280_03C0);
    rw(0, OFS_RAW_INT, 0); chk("lock clr", rd, 0);
    chk("use pll early", sysclk_use_pll, 0);
    chk("out en", pll_out_enable, 1);
    tick(20); rw(0, OFS_RAW_INT, 0); chk("lock slow", rd, 32'h0000_0040);
    chk("use pll", sysclk_use_pll, 1);
    rw(0, OFS_PLL_TRANS, 0); chk("xlate 8192", rd, xl(8192));
    chk("mult 8192", pll_mult, xl(8192));
    rw(1, OFS_INT_MASK, 32'h0000_0040); tick(2); chk("irq", pll_lock_irq, 1);
    rw(1, OFS_RUN_CFG, 32'h0280_0400);
    rw(0, OFS_RAW_INT, 0); chk("relock", rd, 0);
    tick(16); rw(0, OFS_RAW_INT, 0); chk("fast busy", rd, 0);
    tick(20); rw(0, OFS_RAW_INT, 0); chk("fast lock", rd, 32'h0000_0040);
    rw(0, OFS_PLL_TRANS, 0); chk("xlate 10000", rd, xl(10000));
    rw(1, OFS_RUN_CFG, 32'h0280_0400);
    rw(0, OFS_RAW_INT, 0); chk("same crystal_select", rd, 32'h0000_0040);
    $display("relock test done");
    rw(1, OFS_RUN_CFG, 32'h0280_0401); tick(3); chk("dis run", internal_osc_enable, 1);
    deep_sleep <= 1'b1; tick(3); chk("dis sleep", internal_osc_enable, 0);
    rw(1, OFS_MAIN_OSC_CTL, 1); tick(2); chk("check on", main_osc_check_active, 1);
    main_osc_fault <= 1'b1;
    n = 0;
    while (internal_reset !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    main_osc_fault <= 1'b0;
    tick(1); chk("fb osc", internal_osc_enable, 1);
    chk("fb src", sysclk_src_internal, 1);
    n = 1;
    while (internal_reset === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk("por len", n, POR_CYCLES);
    tick(3); chk("nmi", nmis, 1);
    rw(0, OFS_RST_CAUSE, 0); chk("fail flag", rd, 32'h0001_0000);
    rw(1, OFS_RST_CAUSE, 32'h0001_0000);
    rw(0, OFS_RST_CAUSE, 0); chk("flag clr", rd, 0);
    deep_sleep <= 1'b0;
    $display("fault test done");
    final_report();
  end
endmodule
`default_nettype wire
